/* rtl/bxu_pkg.sv */
/*
 * Constants, field layouts and types for the byte ALU execute unit.
 * Assumes nothing beyond a SystemVerilog compiler; shared by all design files.
 */
package bxu_pkg;
	localparam int IADDR_W   = 12;
	localparam int IWORD_W   = 18;
	localparam int DADDR_W   = 8;
	localparam int DATA_W    = 8;
	localparam int REG_IDX_W = 3;
	localparam int NUM_REGS  = 8;

	// Instruction field positions.
	localparam int F_RFORM_HI = 17;
	localparam int F_RFORM_LO = 14;
	localparam int F_IMM_SEL  = 17;
	localparam int F_IOP_HI   = 16;
	localparam int F_IOP_LO   = 14;
	localparam int F_RD_HI    = 13;
	localparam int F_RD_LO    = 11;
	localparam int F_RA_HI    = 10;
	localparam int F_RA_LO    = 8;
	localparam int F_RB_HI    = 7;
	localparam int F_RB_LO    = 5;
	localparam int F_FN_HI    = 2;
	localparam int F_FN_LO    = 0;
	localparam int F_LIT_HI   = 7;
	localparam int F_LIT_LO   = 0;

	localparam logic [3:0]            RFORM_CODE = 4'he;
	localparam logic [REG_IDX_W-1:0]  ZERO_REG   = 3'h0;
	localparam logic [DATA_W-1:0]     ZERO_BYTE  = 8'h00;
	localparam logic [IADDR_W-1:0]    PC_RESET   = 12'h000;

	typedef enum logic [2:0] {
		BXU_ADD  = 3'h0,
		BXU_ADDC = 3'h1,
		BXU_SUB  = 3'h2,
		BXU_SUBC = 3'h3,
		BXU_AND  = 3'h4,
		BXU_OR   = 3'h5,
		BXU_XOR  = 3'h6,
		BXU_CLRB = 3'h7
	} bxu_func_type;
endpackage

/* rtl/bxu_rf_if.sv */
/*
 * Interface joining the execute unit to its register file.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface bxu_rf_if;
	import bxu_pkg::*;
	logic [REG_IDX_W-1:0] rd_a_idx;
	logic [REG_IDX_W-1:0] rd_b_idx;
	logic [DATA_W-1:0]    rd_a_data;
	logic [DATA_W-1:0]    rd_b_data;
	logic                 wr_en;
	logic [REG_IDX_W-1:0] wr_idx;
	logic [DATA_W-1:0]    wr_data;

	modport core (output rd_a_idx, output rd_b_idx, input rd_a_data, input rd_b_data,
		output wr_en, output wr_idx, output wr_data);
	modport regs (input rd_a_idx, input rd_b_idx, output rd_a_data, output rd_b_data,
		input wr_en, input wr_idx, input wr_data);
endinterface

/* rtl/bxu_regfile.sv */
/*
 * Eight-entry byte register file with a hard zero entry.
 * Assumes writes are presented for one clock by the execute unit.
 */
`timescale 1ns/1ps
module bxu_regfile
	import bxu_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_srst,
	bxu_rf_if.regs    rf
);
	logic [DATA_W-1:0] regs_q [NUM_REGS];

	// Index zero is never stored, so it cannot be corrupted by any write.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_q[i] <= ZERO_BYTE;
		end
		else if (rf.wr_en && rf.wr_idx != ZERO_REG)
			regs_q[rf.wr_idx] <= rf.wr_data;
	end

	// Reads of index zero return a constant zero.
	assign rf.rd_a_data = (rf.rd_a_idx == ZERO_REG) ? ZERO_BYTE : regs_q[rf.rd_a_idx];
	assign rf.rd_b_data = (rf.rd_b_idx == ZERO_REG) ? ZERO_BYTE : regs_q[rf.rd_b_idx];
endmodule

/* rtl/bxu_core.sv */
/*
 * Byte ALU execute unit: program counter, instruction fetch address,
 * decode of register and literal forms, eight ALU functions, flags.
 * Assumes instruction memory answers combinationally with the word at
 * o_iaddr, and that non-ALU instructions are executed elsewhere.
 */
// Contract
// - Fetch from up to 4096 eighteen-bit words by twelve-bit address.
// - Data memory holds 256 bytes via an eight-bit address.
// - Reset clears the program counter, then fetching starts there.
// - Eight registers by three-bit index; index zero reads zero, ignores writes.
// - Two flags: zero-result flag and carry/borrow flag.
// - Second operand is register B or eight-bit literal per form.
// - Register form: top nibble 1110, fields dest, A, B, function.
// - Literal form: bit 17 clear, bits 16-14 function, literal low byte.
// - Add writes A plus operand; carry out into spill bit.
// - Add with carry includes current spill bit; new carry loaded.
// - Subtract writes A minus operand; borrow into spill bit.
// - Subtract with borrow also subtracts spill bit; new borrow loaded.
// - AND, OR, XOR write bitwise results of A and operand.
// - Clear-bits writes A AND NOT operand.
// - Logical operations clear the spill bit.
// - Null flag set when eight-bit result is zero, else cleared.
// - Values are bytes; carry and borrow taken at bit eight.
`timescale 1ns/1ps
module bxu_core
	import bxu_pkg::*;
#(
	parameter int P_IADDR_W = 12,
	parameter int P_DADDR_W = 8
)
(
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_srst,
	input  wire logic [bxu_pkg::IWORD_W-1:0] i_instr,
	output logic      [P_IADDR_W-1:0]        o_iaddr,
	output logic      [P_DADDR_W-1:0]        o_daddr,
	output logic                             o_null_flag,
	output logic                             o_spill_bit,
	output logic                             o_alu_valid,
	output logic      [bxu_pkg::DATA_W-1:0]  o_result,
	output logic      [bxu_pkg::REG_IDX_W-1:0] o_dest
);
	import bxu_pkg::*;

	// The widths are fixed by the instruction set; other values would mis-slice fields.
	if (P_IADDR_W != IADDR_W || P_DADDR_W != DADDR_W)
	begin
		$error("bxu_core: address widths must be 12 and 8");
	end

	// Result of one ALU step: byte plus carry/borrow out.
	typedef struct packed {
		logic              spill;
		logic [DATA_W-1:0] value;
	} bxu_alu_out_type;

	// Shared add/subtract with incoming carry or borrow, taken at bit eight.
	function automatic bxu_alu_out_type bxu_addsub(input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b, input logic cin, input logic sub);
		logic [DATA_W:0] wide;
		wide = '0;
		if (sub)
			wide = {1'b0, a} - {1'b0, b} - {{DATA_W{1'b0}}, cin};
		else
			wide = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
		return {wide[DATA_W], wide[DATA_W-1:0]};
	endfunction

	bxu_rf_if rf ();

	bxu_regfile u_regfile (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.rf        (rf.regs)
	);

	logic [IADDR_W-1:0]   pc_q;
	logic                 null_q;
	logic                 spill_q;
	logic                 is_rform;
	logic                 is_iform;
	logic                 is_alu;
	bxu_func_type         func;
	logic [DATA_W-1:0]    opnd_a;
	logic [DATA_W-1:0]    second_operand;
	logic [DATA_W-1:0]    literal_operand;
	logic [REG_IDX_W-1:0] dest_reg;
	bxu_alu_out_type      alu;

	assign is_rform = (i_instr[F_RFORM_HI:F_RFORM_LO] == RFORM_CODE);
	assign is_iform = ~i_instr[F_IMM_SEL];
	assign is_alu   = is_rform | is_iform;
	assign func     = is_rform ? bxu_func_type'(i_instr[F_FN_HI:F_FN_LO])
		: bxu_func_type'(i_instr[F_IOP_HI:F_IOP_LO]);
	assign dest_reg        = i_instr[F_RD_HI:F_RD_LO];
	assign literal_operand = i_instr[F_LIT_HI:F_LIT_LO];

	assign rf.rd_a_idx = i_instr[F_RA_HI:F_RA_LO];
	assign rf.rd_b_idx = i_instr[F_RB_HI:F_RB_LO];
	assign opnd_a      = rf.rd_a_data;
	assign second_operand = is_rform ? rf.rd_b_data : literal_operand;

	// Function unit; logical ops leave spill low, arithmetic take it at bit eight.
	always_comb
	begin
		alu = '0;
		unique case (func)
			BXU_ADD:  alu = bxu_addsub(opnd_a, second_operand, 1'b0, 1'b0);
			BXU_ADDC: alu = bxu_addsub(opnd_a, second_operand, spill_q, 1'b0);
			BXU_SUB:  alu = bxu_addsub(opnd_a, second_operand, 1'b0, 1'b1);
			BXU_SUBC: alu = bxu_addsub(opnd_a, second_operand, spill_q, 1'b1);
			BXU_AND:  alu = {1'b0, opnd_a & second_operand};
			BXU_OR:   alu = {1'b0, opnd_a | second_operand};
			BXU_XOR:  alu = {1'b0, opnd_a ^ second_operand};
			BXU_CLRB: alu = {1'b0, opnd_a & ~second_operand};
		endcase
	end

	// write dropped by the file, flags still follow
	assign rf.wr_en   = is_alu & ~i_srst;
	assign rf.wr_idx  = dest_reg;
	assign rf.wr_data = alu.value;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			pc_q <= PC_RESET;
		else
			pc_q <= pc_q + IADDR_W'(1);
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			null_q  <= 1'b0;
			spill_q <= 1'b0;
		end
		else if (is_alu)
		begin
			null_q  <= (alu.value == ZERO_BYTE);
			spill_q <= alu.spill;
		end
	end

	// Registered copy of the step result for observation by the control logic.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			o_alu_valid <= 1'b0;
			o_result    <= ZERO_BYTE;
			o_dest      <= ZERO_REG;
		end
		else
		begin
			o_alu_valid <= is_alu;
			o_result    <= alu.value;
			o_dest      <= dest_reg;
		end
	end

	// fetch address; data address is unused by ALU ops, held zero.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			o_iaddr <= PC_RESET;
			o_daddr <= '0;
		end
		else
		begin
			o_iaddr <= pc_q + IADDR_W'(1);
			o_daddr <= '0;
		end
	end

	assign o_null_flag = null_q;
	assign o_spill_bit = spill_q;
endmodule

/* sim/bxu_rom_model.sv */
/*
 * Instruction memory model feeding the execute unit.
 * Assumes the bench fills mem before reset is released.
 */
`timescale 1ns/1ps
module bxu_rom_model
	import bxu_pkg::*;
(
	input  wire logic [bxu_pkg::IADDR_W-1:0] i_addr,
	output logic      [bxu_pkg::IWORD_W-1:0] o_word
);
	logic [IWORD_W-1:0] mem [0:31];

	// word per address
	// Past the program a shift word is returned, which must leave the flags alone.
	assign o_word = (i_addr < 12'h020) ? mem[i_addr[4:0]] : 18'h30000;
endmodule

/* sim/bxu_core_checker.sv */
/*
 * Port-level properties of the execute unit.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module bxu_core_checker
	import bxu_pkg::*;
#(
	parameter int P_IADDR_W = 12,
	parameter int P_DADDR_W = 8
)
(
	input wire logic                          i_clk_sys,
	input wire logic                          i_srst,
	input wire logic [bxu_pkg::IWORD_W-1:0]   i_instr,
	input wire logic [P_IADDR_W-1:0]          o_iaddr,
	input wire logic [P_DADDR_W-1:0]          o_daddr,
	input wire logic                          o_null_flag,
	input wire logic                          o_spill_bit,
	input wire logic                          o_alu_valid,
	input wire logic [bxu_pkg::DATA_W-1:0]    o_result,
	input wire logic [bxu_pkg::REG_IDX_W-1:0] o_dest
);
	logic       is_alu;
	logic [2:0] fn;

	// Both ALU forms are recognised; every other word is left alone.
	assign is_alu = (i_instr[17:14] == RFORM_CODE) || !i_instr[17];
	assign fn     = i_instr[17] ? i_instr[2:0] : i_instr[16:14];

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	sequence s_take;
		!i_srst && is_alu;
	endsequence

	property p_pc_step;
		!i_srst |=> o_iaddr == $past(o_iaddr) + 1'b1;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("fetch address did not step");
	property p_daddr;
		o_daddr == '0;
	endproperty
	a_daddr: assert property (p_daddr) else $error("data address moved");
	property p_dest;
		s_take |=> o_alu_valid && o_dest == $past(i_instr[13:11]);
	endproperty
	a_dest: assert property (p_dest) else $error("destination index wrong");
	property p_hold;
		!i_srst && !is_alu |=> !o_alu_valid && $stable(o_null_flag) && $stable(o_spill_bit);
	endproperty
	a_hold: assert property (p_hold) else $error("flags changed on a non-ALU word");
	property p_logic;
		s_take ##0 fn[2] |=> !o_spill_bit;
	endproperty
	a_logic: assert property (p_logic) else $error("logic op left carry set");
	property p_null;
		o_alu_valid |-> o_null_flag == (o_result == 8'h00);
	endproperty
	a_null: assert property (p_null) else $error("zero flag disagrees with result");
	property p_zero_src;
		s_take ##0 (!i_instr[17] && fn == BXU_ADD && i_instr[10:8] == ZERO_REG)
			|=> o_result == $past(i_instr[7:0]) && !o_spill_bit;
	endproperty
	a_zero_src: assert property (p_zero_src) else $error("zero register not read as zero");
	property p_clr_self;
		s_take ##0 (i_instr[17] && fn == BXU_CLRB && i_instr[10:8] == i_instr[7:5])
			|=> o_result == 8'h00 && o_null_flag;
	endproperty
	a_clr_self: assert property (p_clr_self) else $error("clear-bits of itself not zero");
endmodule

bind bxu_core bxu_core_checker #(.P_IADDR_W(P_IADDR_W), .P_DADDR_W(P_DADDR_W)) u_bxu_core_checker (
	.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_instr(i_instr), .o_iaddr(o_iaddr),
	.o_daddr(o_daddr), .o_null_flag(o_null_flag), .o_spill_bit(o_spill_bit),
	.o_alu_valid(o_alu_valid), .o_result(o_result), .o_dest(o_dest));

/* sim/byte_alu_execute_unit_tb_top.sv */
/*
 * Self-checking bench: runs a short program and compares every step.
 * Assumes the core fetches one word per cycle from the model memory.
 */
`timescale 1ns/1ps
module byte_alu_execute_unit_tb_top;
	import bxu_pkg::*;
	logic        clk_sys = 1'b0;
	logic        srst    = 1'b1;
	logic [17:0] instr;
	logic [11:0] iaddr;
	logic [7:0]  daddr;
	logic [7:0]  result;
	logic        nflag;
	logic        sbit;
	logic        valid;
	logic [2:0]  dest;
	logic [7:0]  mr [0:7];
	logic [17:0] prog [0:19];
	logic        mz = 1'b0;
	logic        mc = 1'b0;
	int          bad_count = 0;
	int          samples_checked = 0;

	always #2.5 clk_sys = ~clk_sys;
	bxu_core u_bxu_core (.i_clk_sys(clk_sys), .i_srst(srst), .i_instr(instr), .o_iaddr(iaddr),
		.o_daddr(daddr), .o_null_flag(nflag), .o_spill_bit(sbit), .o_alu_valid(valid),
		.o_result(result), .o_dest(dest));
	bxu_rom_model u_bxu_rom_model (.i_addr(iaddr), .o_word(instr));

	function automatic logic [17:0] fi(logic [2:0] o, d, s, logic [7:0] l);
		return {1'b0, o, d, s, l};
	endfunction
	function automatic logic [17:0] fr(logic [2:0] o, d, s, t);
		return {4'he, d, s, t, 2'b00, o};
	endfunction

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	// Reference step worked out from the word, then compared one edge later.
	task automatic step(input int k);
		logic [17:0] w;
		logic [2:0]  f;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [8:0]  x;
		logic        alu;
		w = u_bxu_rom_model.mem[k];
		alu = (w[17:14] == 4'he) || !w[17];
		f = w[17] ? w[2:0] : w[16:14];
		a = mr[w[10:8]];
		b = w[17] ? mr[w[7:5]] : w[7:0];
		case (f)
			3'h0: x = a + b;
			3'h1: x = a + b + mc;
			3'h2: x = a - b;
			3'h3: x = a - b - mc;
			3'h4: x = a & b;
			3'h5: x = a | b;
			3'h6: x = a ^ b;
			default: x = a & ~b;
		endcase
		@(posedge clk_sys);
		#1;
		chk("iaddr", 8'(k + 1), iaddr[7:0]);
		chk("valid", {7'h0, alu}, {7'h0, valid});
		if (alu)
		begin
			mc = f[2] ? 1'b0 : x[8];
			mz = (x[7:0] == 8'h00);
			if (w[13:11] != 3'h0)
				mr[w[13:11]] = x[7:0];
			chk("result", x[7:0], result);
			chk("dest", {5'h0, w[13:11]}, {5'h0, dest});
		end
		chk("flags", {6'h0, mz, mc}, {6'h0, nflag, sbit});
	endtask

	task automatic t_arith_ops();
		for (int k = 0; k < 5; k++)
			step(k);
		$display("test arith done");
	endtask

	task automatic t_logic_ops();
		for (int k = 5; k < 20; k++)
			step(k);
		$display("test logic done");
	endtask

	task automatic summarize();
		$display("checked %0d mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// The run needs about 26 cycles; this bound only catches a hang.
	initial
	begin
		#2000;
		bad_count++;
		summarize();
	end

	initial
	begin
		mr = '{default: 8'h00};
		prog = '{fi(0, 1, 0, 8'hff), fi(0, 2, 1, 8'h01), fi(1, 3, 1, 8'h00),
			fi(2, 4, 0, 8'h01), fr(3, 5, 0, 0), fr(4, 6, 1, 5), fr(5, 7, 2, 3),
			fi(6, 1, 1, 8'h0f), fr(7, 2, 1, 6), fi(0, 0, 1, 8'h10), fr(0, 3, 0, 1), 18'h30000,
			fi(3, 4, 1, 8'h0f), fi(4, 5, 1, 8'h30), fi(5, 6, 0, 8'h00), fi(7, 7, 1, 8'hf0),
			fr(1, 1, 1, 1), fr(2, 2, 1, 6), fr(6, 3, 1, 1), fr(7, 5, 1, 1)};
		// Words past the program are shift words, which leave the flags alone.
		for (int i = 0; i < 32; i++)
			u_bxu_rom_model.mem[i] = (i < 20) ? prog[i] : 18'h30000;
		repeat (6) @(posedge clk_sys);
		#1;
		chk("reset iaddr", 8'h00, iaddr[7:0]);
		chk("reset daddr", 8'h00, daddr);
		srst = 1'b0;
		$display("test reset done");
		t_arith_ops();
		t_logic_ops();
		summarize();
	end
endmodule
